// ### hw/atg_pkg.sv
package atg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and serial port timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_STAGES = 2;
  // sclk must stay high and low this many clocks at least
  localparam int SCLK_MIN_PHASE_CYCLES = 4;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout: 7 address bits, read flag, 8 data bits, msb first
  localparam int ADDR_W = 7;
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
  localparam logic [4:0] BIT_DATA_LAST = 5'h0f;
  localparam logic [4:0] BIT_FRAME_END = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [6:0] ADDR_DROP_COUNT_HIGH = 7'h0f;
  localparam logic [6:0] ADDR_DROP_COUNT_LOW = 7'h10;
  localparam logic [6:0] ADDR_CURRENT_THRESHOLD_HIGH = 7'h11;
  localparam logic [6:0] ADDR_CURRENT_THRESHOLD_LOW = 7'h12;
  localparam logic [6:0] ADDR_AMPLIFIER_GAIN_CONTROL = 7'h13;
  localparam logic [6:0] ADDR_CHOPPER_POWER_CONTROL = 7'h14;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and writable bit masks
  localparam logic [7:0] RST_DROP_COUNT = 8'h00;
  localparam logic [7:0] RST_CURRENT_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_AMPLIFIER_GAIN_CONTROL = 8'h50;
  localparam logic [7:0] RST_CHOPPER_POWER_CONTROL = 8'hc0;
  localparam logic [7:0] MASK_AMPLIFIER_GAIN_CONTROL = 8'hf0;
  localparam logic [7:0] MASK_CHOPPER_POWER_CONTROL = 8'hc0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int GAIN_CURRENT_MSB = 7;
  localparam int GAIN_CURRENT_LSB = 6;
  localparam int GAIN_VOLTAGE_MSB = 5;
  localparam int GAIN_VOLTAGE_LSB = 4;
  localparam int CHOP_CURRENT_BIT = 7;
  localparam int CHOP_VOLTAGE_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // gain codes and factors
  localparam logic [1:0] GAIN_CODE_5 = 2'h0;
  localparam logic [1:0] GAIN_CODE_25 = 2'h1;
  localparam logic [1:0] GAIN_CODE_40 = 2'h2;
  localparam logic [1:0] GAIN_CODE_100 = 2'h3;
  localparam logic [6:0] GAIN_FACTOR_5 = 7'h05;
  localparam logic [6:0] GAIN_FACTOR_25 = 7'h19;
  localparam logic [6:0] GAIN_FACTOR_40 = 7'h28;
  localparam logic [6:0] GAIN_FACTOR_100 = 7'h64;

  typedef enum logic [1:0] {
    ATG_GAIN_5,
    ATG_GAIN_25,
    ATG_GAIN_40,
    ATG_GAIN_100
  } atg_gain_code_t;

  typedef struct packed {
    logic [1:0] gain_current_code;
    logic [1:0] gain_voltage_code;
    logic chop_current_en;
    logic chop_voltage_en;
  } atg_config_t;

  typedef struct packed {
    logic [15:0] drop_count;
    logic [15:0] current_threshold;
  } atg_trigger_t;

endpackage : atg_pkg

// ### hw/atg_regs.sv
`timescale 1ns/1ps

module atg_regs (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE,
  input wire logic I_THRESHOLD_MODE,
  input wire logic I_SAMPLE_VALID,
  input wire logic [15:0] I_SAMPLE,
  output logic O_IRQ,
  output atg_pkg::atg_config_t O_CONFIG,
  output atg_pkg::atg_trigger_t O_TRIGGER,
  output logic [6:0] O_GAIN_CURRENT,
  output logic [6:0] O_GAIN_VOLTAGE
);

  function automatic logic [6:0] gain_factor(input logic [1:0] code);
    case (code)
      atg_pkg::GAIN_CODE_5: gain_factor = atg_pkg::GAIN_FACTOR_5;
      atg_pkg::GAIN_CODE_25: gain_factor = atg_pkg::GAIN_FACTOR_25;
      atg_pkg::GAIN_CODE_40: gain_factor = atg_pkg::GAIN_FACTOR_40;
      default: gain_factor = atg_pkg::GAIN_FACTOR_100;
    endcase
  endfunction : gain_factor

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;

  atg_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h2)
  ) u_sync (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_async({I_SCLK, I_CS_N, I_SDI}),
    .o_sync(pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign sdi_s = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine
  logic sclk_d_reg, sclk_d_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_reg, rx_next;
  logic [6:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic [7:0] tx_reg, tx_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_mux;

  logic [7:0] drop_hi_reg, drop_hi_next;
  logic [7:0] drop_lo_reg, drop_lo_next;
  logic [7:0] th_hi_reg, th_hi_next;
  logic [7:0] th_lo_reg, th_lo_next;
  logic [7:0] pga_reg, pga_next;
  logic [7:0] chop_reg, chop_next;
  logic [6:0] gain_i_reg, gain_i_next;
  logic [6:0] gain_v_reg, gain_v_next;

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;

  // read data for the address just shifted in; unmapped reads zero
  always_comb begin
    case (rx_reg[6:0])
      atg_pkg::ADDR_DROP_COUNT_HIGH: rd_mux = drop_hi_reg;
      atg_pkg::ADDR_DROP_COUNT_LOW: rd_mux = drop_lo_reg;
      atg_pkg::ADDR_CURRENT_THRESHOLD_HIGH: rd_mux = th_hi_reg;
      atg_pkg::ADDR_CURRENT_THRESHOLD_LOW: rd_mux = th_lo_reg;
      atg_pkg::ADDR_AMPLIFIER_GAIN_CONTROL: rd_mux = pga_reg;
      atg_pkg::ADDR_CHOPPER_POWER_CONTROL: rd_mux = chop_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    sclk_d_next = sclk_s;
    bit_cnt_next = bit_cnt_reg;
    rx_next = rx_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    tx_next = tx_reg;
    sdo_next = sdo_reg;
    oe_next = ~cs_n_s;
    wr_en = 1'b0;
    wr_data = {rx_reg[6:0], sdi_s};
    if (cs_n_s) begin
      bit_cnt_next = 5'h00;
      sdo_next = 1'b0;
    end else if (sclk_rise) begin
      rx_next = {rx_reg[6:0], sdi_s};
      if (bit_cnt_reg != atg_pkg::BIT_FRAME_END) begin
        bit_cnt_next = bit_cnt_reg + 5'h01;
      end
      if (bit_cnt_reg == atg_pkg::BIT_ADDR_LAST) begin
        addr_next = rx_reg[6:0];
        rd_next = sdi_s;
        tx_next = rd_mux;
      end
      if (bit_cnt_reg == atg_pkg::BIT_DATA_LAST && !rd_reg) begin
        wr_en = 1'b1;
      end
    end else if (sclk_fall && rd_reg && bit_cnt_reg >= atg_pkg::BIT_DATA_FIRST &&
                 bit_cnt_reg < atg_pkg::BIT_FRAME_END) begin
      sdo_next = tx_reg[7];
      tx_next = {tx_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      rx_reg <= 8'h00;
      addr_reg <= 7'h00;
      rd_reg <= 1'b0;
      tx_reg <= 8'h00;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      tx_reg <= tx_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank
  always_comb begin
    drop_hi_next = drop_hi_reg;
    drop_lo_next = drop_lo_reg;
    th_hi_next = th_hi_reg;
    th_lo_next = th_lo_reg;
    pga_next = pga_reg;
    chop_next = chop_reg;
    if (wr_en) begin
      case (addr_reg)
        atg_pkg::ADDR_DROP_COUNT_HIGH: drop_hi_next = wr_data;
        atg_pkg::ADDR_DROP_COUNT_LOW: drop_lo_next = wr_data;
        atg_pkg::ADDR_CURRENT_THRESHOLD_HIGH: th_hi_next = wr_data;
        atg_pkg::ADDR_CURRENT_THRESHOLD_LOW: th_lo_next = wr_data;
        atg_pkg::ADDR_AMPLIFIER_GAIN_CONTROL: begin
          pga_next = wr_data & atg_pkg::MASK_AMPLIFIER_GAIN_CONTROL;
        end
        atg_pkg::ADDR_CHOPPER_POWER_CONTROL: begin
          chop_next = wr_data & atg_pkg::MASK_CHOPPER_POWER_CONTROL;
        end
        default: begin
        end
      endcase
    end
    gain_i_next = gain_factor(pga_next[atg_pkg::GAIN_CURRENT_MSB:atg_pkg::GAIN_CURRENT_LSB]);
    gain_v_next = gain_factor(pga_next[atg_pkg::GAIN_VOLTAGE_MSB:atg_pkg::GAIN_VOLTAGE_LSB]);
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      drop_hi_reg <= atg_pkg::RST_DROP_COUNT;
      drop_lo_reg <= atg_pkg::RST_DROP_COUNT;
      th_hi_reg <= atg_pkg::RST_CURRENT_THRESHOLD;
      th_lo_reg <= atg_pkg::RST_CURRENT_THRESHOLD;
      pga_reg <= atg_pkg::RST_AMPLIFIER_GAIN_CONTROL;
      chop_reg <= atg_pkg::RST_CHOPPER_POWER_CONTROL;
      gain_i_reg <= atg_pkg::GAIN_FACTOR_25;
      gain_v_reg <= atg_pkg::GAIN_FACTOR_25;
    end else begin
      drop_hi_reg <= drop_hi_next;
      drop_lo_reg <= drop_lo_next;
      th_hi_reg <= th_hi_next;
      th_lo_reg <= th_lo_next;
      pga_reg <= pga_next;
      chop_reg <= chop_next;
      gain_i_reg <= gain_i_next;
      gain_v_reg <= gain_v_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold-triggered discard and interrupt
  typedef enum logic [1:0] {
    ATG_ST_IDLE,
    ATG_ST_DROP,
    ATG_ST_DONE
  } atg_state_t;

  atg_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic irq_reg, irq_next;
  logic [15:0] drop_count;
  logic [15:0] threshold;

  assign drop_count = {drop_hi_reg, drop_lo_reg};
  assign threshold = {th_hi_reg, th_lo_reg};

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    irq_next = 1'b0;
    if (!I_THRESHOLD_MODE) begin
      state_next = ATG_ST_IDLE;
      cnt_next = 16'h0000;
    end else begin
      case (state_reg)
        ATG_ST_IDLE: begin
          if (I_SAMPLE_VALID && I_SAMPLE >= threshold) begin
            cnt_next = 16'h0000;
            if (drop_count == 16'h0000) begin
              irq_next = 1'b1;
              state_next = ATG_ST_DONE;
            end else begin
              state_next = ATG_ST_DROP;
            end
          end
        end
        ATG_ST_DROP: begin
          if (I_SAMPLE_VALID) begin
            cnt_next = 16'(cnt_reg + 16'h0001);
            if (16'(cnt_reg + 16'h0001) == drop_count) begin
              irq_next = 1'b1;
              state_next = ATG_ST_DONE;
            end
          end
        end
        ATG_ST_DONE: state_next = ATG_ST_DONE;
        default: state_next = ATG_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ATG_ST_IDLE;
      cnt_reg <= 16'h0000;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign O_SDO = sdo_reg;
  assign O_SDO_OE = oe_reg;
  assign O_IRQ = irq_reg;
  assign O_GAIN_CURRENT = gain_i_reg;
  assign O_GAIN_VOLTAGE = gain_v_reg;
  assign O_CONFIG.gain_current_code =
    pga_reg[atg_pkg::GAIN_CURRENT_MSB:atg_pkg::GAIN_CURRENT_LSB];
  assign O_CONFIG.gain_voltage_code =
    pga_reg[atg_pkg::GAIN_VOLTAGE_MSB:atg_pkg::GAIN_VOLTAGE_LSB];
  assign O_CONFIG.chop_current_en = chop_reg[atg_pkg::CHOP_CURRENT_BIT];
  assign O_CONFIG.chop_voltage_en = chop_reg[atg_pkg::CHOP_VOLTAGE_BIT];
  assign O_TRIGGER.drop_count = drop_count;
  assign O_TRIGGER.current_threshold = threshold;

endmodule : atg_regs

// ### hw/atg_sync.sv
`timescale 1ns/1ps

module atg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("atg_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : atg_sync

// ### testbench/acq_threshold_gain_regs_tb_top.sv
`timescale 1ns/1ps
module acq_threshold_gain_regs_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic vld = 1'b0;
  logic tgl = 1'b0;
  logic [15:0] smp = 16'h0000;
  logic sclk, cs_n, sdi, sdo, sdo_oe, irq, sdo_w;
  logic [6:0] gc, gv;
  atg_pkg::atg_config_t cfg;
  atg_pkg::atg_trigger_t trg;
  logic [7:0] mdl [0:127];
  integer num_errors = 0;
  integer check_count = 0;
  integer seed = 32'he5d0605a;
  // floating sdo toggles so a stale bit never matches by luck
  assign sdo_w = sdo_oe ? sdo : tgl;
  always @(posedge clk) tgl <= ~tgl;
  initial forever #10 clk = ~clk;
  atg_host_model i_host (.i_clock(clk), .i_sdo(sdo_w), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_sdi(sdi));
  atg_regs i_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_THRESHOLD_MODE(mode),
    .I_SAMPLE_VALID(vld), .I_SAMPLE(smp), .O_IRQ(irq), .O_CONFIG(cfg), .O_TRIGGER(trg),
    .O_GAIN_CURRENT(gc), .O_GAIN_VOLTAGE(gv));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [6:0] gf(input logic [1:0] c);
    gf = c == 2'h0 ? 7'd5 : c == 2'h1 ? 7'd25 : c == 2'h2 ? 7'd40 : 7'd100;
  endfunction : gf
  task automatic chk_out();
    chk("config", 32'({mdl[19][7:4], mdl[20][7:6]}), 32'(cfg));
    chk("gains", 32'({gf(mdl[19][7:6]), gf(mdl[19][5:4])}), 32'({gc, gv}));
    chk("trigger", {mdl[15], mdl[16], mdl[17], mdl[18]}, trg);
    chk("sdo_idle", 32'h0, 32'({sdo_oe, sdo}));
  endtask : chk_out
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(a, 1'b0, d, q);
    if (a >= 7'h0f && a <= 7'h12) mdl[a] = d;
    if (a == 7'h13) mdl[a] = d & 8'hf0;
    if (a == 7'h14) mdl[a] = d & 8'hc0;
    chk_out();
  endtask : wr
  task automatic rd(input logic [6:0] a);
    logic [7:0] q;
    i_host.xfer(a, 1'b1, 8'h00, q);
    chk("read_data", 32'(mdl[a]), 32'(q));
  endtask : rd
  task automatic run_mode(input int n);
    int st;
    int cnt;
    logic ex;
    st = 0;
    cnt = 0;
    wr(7'h0f, 8'(n >> 8));
    wr(7'h10, 8'(n));
    for (int k = 0; k < 90; k++) begin
      @(posedge clk);
      ex = 1'b0;
      if (!mode) begin
        st = 0;
      end else if (vld && st == 1) begin
        cnt++;
        ex = cnt == n;
        st = ex ? 2 : 1;
      end else if (vld && st == 0 && smp >= {mdl[17], mdl[18]}) begin
        cnt = 0;
        ex = n == 0;
        st = ex ? 2 : 1;
      end
      #1;
      chk("irq", 32'(ex), 32'(irq));
      mode = k % 40 < 37;
      vld = 1'($random(seed));
      smp = k % 7 == 0 ? {mdl[17], mdl[18]} : 16'($random(seed));
    end
    mode = 1'b0;
    vld = 1'b0;
  endtask : run_mode
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[19] = 8'h50;
    mdl[20] = 8'hc0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_out();
    for (int a = 14; a < 22; a++) rd(7'(a));
    for (int c = 0; c < 4; c++) begin
      wr(7'h13, {c[1:0], 2'(3 - c), 4'hf});
      wr(7'h14, {c[1:0], 6'h3f});
      rd(7'h13);
      rd(7'h14);
    end
    repeat (12) wr(7'h0f + 7'(3'($random(seed))), 8'($random(seed)));
    for (int a = 15; a < 23; a++) rd(7'(a));
    wr(7'h11, 8'($random(seed)) & 8'h7f);
    run_mode(0);
    run_mode(1);
    run_mode(4);
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule : acq_threshold_gain_regs_tb_top

// ### testbench/atg_host_model.sv
`timescale 1ns/1ps
module atg_host_model (
  input wire logic i_clock,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // five clocks per phase clears the four clock minimum
  task automatic wt();
    repeat (5) @(posedge i_clock);
    #1;
  endtask : wt
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d,
    output logic [7:0] q);
    logic [15:0] f;
    f = {a, rd, d};
    q = 8'h00;
    wt();
    o_cs_n = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      o_sdi = f[k];
      wt();
      o_sclk = 1'b1;
      if (k < 8) begin
        q[k] = i_sdo;
      end
      wt();
      o_sclk = 1'b0;
    end
    wt();
    o_cs_n = 1'b1;
    // released data line must not keep its last level
    o_sdi = ~o_sdi;
    wt();
  endtask : xfer
endmodule : atg_host_model

// ### testbench/atg_regs_assertions.sv
`timescale 1ns/1ps
module atg_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_CS_N,
  input wire logic I_THRESHOLD_MODE,
  input wire logic I_SAMPLE_VALID,
  input wire logic O_IRQ,
  input wire atg_pkg::atg_config_t O_CONFIG,
  input wire atg_pkg::atg_trigger_t O_TRIGGER,
  input wire logic [6:0] O_GAIN_CURRENT,
  input wire logic [6:0] O_GAIN_VOLTAGE
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);
  function automatic logic [6:0] gf(input logic [1:0] c);
    gf = c == 2'h0 ? 7'h05 : c == 2'h1 ? 7'h19 : c == 2'h2 ? 7'h28 : 7'h64;
  endfunction : gf
  // four idle clocks: any write has long landed
  sequence idle_s;
    I_CS_N [*4];
  endsequence
  sequence irq_s;
    O_IRQ && I_THRESHOLD_MODE ##1 I_THRESHOLD_MODE [*4];
  endsequence
  gain_cur_a: assert property (O_GAIN_CURRENT == gf(O_CONFIG.gain_current_code))
    else $error("current gain factor differs from its code");
  gain_volt_a: assert property (O_GAIN_VOLTAGE == gf(O_CONFIG.gain_voltage_code))
    else $error("voltage gain factor differs from its code");
  irq_pulse_a: assert property (O_IRQ |=> !O_IRQ)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (O_IRQ |-> $past(I_SAMPLE_VALID) && $past(I_THRESHOLD_MODE))
    else $error("interrupt without a sample in threshold mode");
  irq_once_a: assert property (irq_s |-> !O_IRQ)
    else $error("second interrupt without rearm");
  irq_off_a: assert property (!I_THRESHOLD_MODE [*2] |-> !O_IRQ)
    else $error("interrupt while threshold mode is off");
  cfg_hold_a: assert property (idle_s |-> $stable(O_CONFIG))
    else $error("configuration changed without a frame");
  trig_hold_a: assert property (idle_s |-> $stable(O_TRIGGER))
    else $error("trigger settings changed without a frame");
endmodule : atg_chk

bind atg_regs atg_chk i_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N),
  .I_THRESHOLD_MODE(I_THRESHOLD_MODE), .I_SAMPLE_VALID(I_SAMPLE_VALID), .O_IRQ(O_IRQ),
  .O_CONFIG(O_CONFIG), .O_TRIGGER(O_TRIGGER), .O_GAIN_CURRENT(O_GAIN_CURRENT),
  .O_GAIN_VOLTAGE(O_GAIN_VOLTAGE));
